// [hdl/emrs_top.v]
`timescale 1ns/1ps
`include "emrs_defs.vh"
// Extended management slave: MDC/MDIO frames to a 32-bit internal register bus
module emrs_top (
  input  wire        clk_i,          // 10 MHz system clock
  input  wire        resetn_i,       // Asynchronous reset, active low
  input  wire        ce_i,           // Clock enable, freezes all state when low
  input  wire        mdc_i,          // Management clock pin from host
  input  wire        mdio_i,         // Management data pin, input side
  output reg         mdio_o,         // Management data pin, output side
  output reg         mdio_oe_o,      // High while this block drives MDIO
  input  wire [1:0]  mode_strap_i,   // Management mode strap pins
  input  wire        sys_busy_i,     // Device reset condition in progress
  output reg  [9:0]  reg_addr_o,     // Internal byte address, word aligned
  output reg         reg_rd_o,       // Fetch strobe, no side effects
  input  wire [31:0] reg_rdata_i,    // Read data, valid while fetch strobe high
  input  wire        reg_valid_i,    // Address is mapped
  input  wire        reg_rd16_i,     // Register may be read as one half
  output reg         reg_rd_done_o,  // Read completed, apply side effects
  output reg         reg_wr_o,       // Write strobe for the combined word
  output reg  [31:0] reg_wdata_o     // Combined write data
);

  // One-hot frame states
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_START = 7'h02;
  localparam [6:0] ST_OP    = 7'h04;
  localparam [6:0] ST_PHYA  = 7'h08;
  localparam [6:0] ST_REGA  = 7'h10;
  localparam [6:0] ST_TA    = 7'h20;
  localparam [6:0] ST_DATA  = 7'h40;

  // Synchronised pin levels
  wire       mdc_s;             // MDC after two flops
  wire       mdio_s;            // MDIO after two flops
  wire [1:0] strap_s;           // Strap after two flops

  reg        mdc_d_reg;         // Previous MDC level for edge finding
  reg  [6:0] state_reg;         // Frame state
  reg  [5:0] pre_reg;           // Consecutive preamble ones
  reg  [4:0] cnt_reg;           // Bit count within a field
  reg  [1:0] op_reg;            // Opcode being shifted in
  reg        is_rd_reg;         // Current frame is a read
  reg  [4:0] pa_reg;            // PHY address field
  reg  [4:0] ra_reg;            // Register address field
  reg  [15:0] sh_reg;           // Data shift register, both directions
  reg        busy_d_reg;        // Previous reset-condition level

  reg        rd_open_reg;       // First read half taken, waiting for other
  reg        rd_half_reg;       // Half select of the open read
  reg  [7:0] rd_addr_reg;       // Word address of the open read
  reg  [1:0] rd_kind_reg;       // Role of the read in progress
  reg        rd_fx_reg;         // Side effects due at end of this read
  reg  [31:0] snap_reg;         // Consistent word snapshot

  reg        wr_open_reg;       // First write half staged
  reg        wr_half_reg;       // Half select of the staged write
  reg  [7:0] wr_addr_reg;       // Word address of the staged write
  reg  [15:0] wr_stage_reg;     // Staged write half

  wire       mdc_rise;          // One clock at each MDC rising edge
  wire [4:0] ra_full;           // Register field including the last bit
  wire [7:0] cur_word;          // Word address of current frame
  wire       cur_half;          // Half select of current frame
  wire       frame_ok;          // Frame is ours and protocol enabled
  wire [15:0] wr_data;          // Write data including the last bit
  wire [7:0] wr_word;           // Word address from the stored fields

  // Word address from the two address fields
  function [7:0] word_addr;
    input [4:0] pa;
    input [4:0] ra;
    begin
      word_addr = {pa[3:0], ra[4:1]};
    end
  endfunction

  // Select one half of a word, high half carries bytes 3 and 2
  function [15:0] half_of;
    input [31:0] word;
    input        hi;
    begin
      half_of = hi ? word[31:16] : word[15:0];
    end
  endfunction

  // Pins cross into the clock domain before anything reads them
  emrs_sync #(
    .W (4)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({mode_strap_i, mdio_i, mdc_i}),
    .q_o      ({strap_s, mdio_s, mdc_s})
  );

  assign mdc_rise = mdc_s & ~mdc_d_reg;
  assign ra_full  = {ra_reg[3:0], mdio_s};
  assign cur_word = word_addr(pa_reg, ra_full);
  assign cur_half = ra_full[0];
  assign frame_ok = pa_reg[`EMRS_PA_EXT_BIT] & (strap_s == `EMRS_STRAP_EN);
  assign wr_data  = {sh_reg[14:0], mdio_s};
  // Past the register field only the stored copy of that field is valid
  assign wr_word  = word_addr(pa_reg, ra_reg);

  // Frame engine, pairing logic and register bus side
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mdc_d_reg     <= 1'b0;
      state_reg     <= ST_IDLE;
      pre_reg       <= 6'h00;
      cnt_reg       <= 5'h00;
      op_reg        <= 2'h0;
      is_rd_reg     <= 1'b0;
      pa_reg        <= 5'h00;
      ra_reg        <= 5'h00;
      sh_reg        <= `EMRS_ZERO16;
      busy_d_reg    <= 1'b0;
      rd_open_reg   <= 1'b0;
      rd_half_reg   <= 1'b0;
      rd_addr_reg   <= 8'h00;
      rd_kind_reg   <= `EMRS_KIND_FIRST;
      rd_fx_reg     <= 1'b0;
      snap_reg      <= `EMRS_ZERO32;
      wr_open_reg   <= 1'b0;
      wr_half_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      wr_stage_reg  <= `EMRS_ZERO16;
      mdio_o        <= 1'b0;
      mdio_oe_o     <= 1'b0;
      reg_addr_o    <= 10'h000;
      reg_rd_o      <= 1'b0;
      reg_rd_done_o <= 1'b0;
      reg_wr_o      <= 1'b0;
      reg_wdata_o   <= `EMRS_ZERO32;
    end else if (ce_i) begin
      mdc_d_reg     <= mdc_s;
      busy_d_reg    <= sys_busy_i;
      // Strobes last one clock
      reg_rd_o      <= 1'b0;
      reg_rd_done_o <= 1'b0;
      reg_wr_o      <= 1'b0;

      // Fetch answer arrives while the strobe is high
      if (reg_rd_o) begin
        snap_reg <= reg_valid_i ? reg_rdata_i : `EMRS_ZERO32;
        if (rd_kind_reg == `EMRS_KIND_FIRST) begin
          if (reg_rd16_i) begin
            rd_fx_reg   <= 1'b1;
            rd_open_reg <= 1'b0;
          end else begin
            rd_open_reg <= 1'b1;
          end
        end
      end

      if (mdc_rise) begin
        case (state_reg)
          // Hunt for a full preamble then the first start bit
          ST_IDLE: begin
            if (mdio_s) begin
              if (pre_reg != `EMRS_PRE_ONES) begin
                pre_reg <= pre_reg + 6'h01;
              end
            end else begin
              if (pre_reg == `EMRS_PRE_ONES) begin
                state_reg <= ST_START;
              end
              pre_reg <= 6'h00;
            end
          end
          // Second start bit must be one
          ST_START: begin
            cnt_reg   <= 5'h00;
            state_reg <= mdio_s ? ST_OP : ST_IDLE;
          end
          // Two opcode bits; anything else drops the frame
          ST_OP: begin
            op_reg  <= {op_reg[0], mdio_s};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `EMRS_OP_LAST) begin
              cnt_reg   <= 5'h00;
              is_rd_reg <= ({op_reg[0], mdio_s} == `EMRS_OP_RD);
              if (({op_reg[0], mdio_s} == `EMRS_OP_RD) ||
                  ({op_reg[0], mdio_s} == `EMRS_OP_WR)) begin
                state_reg <= ST_PHYA;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          // PHY address, MSB first
          ST_PHYA: begin
            pa_reg  <= {pa_reg[3:0], mdio_s};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `EMRS_FIELD_LAST) begin
              cnt_reg   <= 5'h00;
              state_reg <= ST_REGA;
            end
          end
          // Register address; decide ownership and pairing at its end
          ST_REGA: begin
            ra_reg  <= ra_full;
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `EMRS_FIELD_LAST) begin
              cnt_reg <= 5'h00;
              if (!frame_ok) begin
                // Not ours: stay off the line, rehunt preamble
                state_reg <= ST_IDLE;
              end else if (is_rd_reg) begin
                state_reg   <= ST_TA;
                reg_addr_o  <= {cur_word, 2'h0};
                // A read breaks any staged write pair
                wr_open_reg <= 1'b0;
                rd_fx_reg   <= 1'b0;
                if (rd_open_reg && (rd_addr_reg == cur_word) &&
                    (rd_half_reg != cur_half)) begin
                  rd_kind_reg <= `EMRS_KIND_SECOND;
                  rd_open_reg <= 1'b0;
                  rd_fx_reg   <= 1'b1;
                end else if (rd_open_reg && (rd_addr_reg == cur_word)) begin
                  rd_kind_reg <= `EMRS_KIND_BAD;
                  rd_open_reg <= 1'b0;
                  reg_rd_o    <= 1'b1;
                end else begin
                  // Fresh first half, fetch a new snapshot
                  rd_kind_reg <= `EMRS_KIND_FIRST;
                  rd_open_reg <= 1'b0;
                  rd_half_reg <= cur_half;
                  rd_addr_reg <= cur_word;
                  reg_rd_o    <= 1'b1;
                end
              end else begin
                // A write breaks any open read pair
                state_reg   <= ST_TA;
                rd_open_reg <= 1'b0;
              end
            end
          end
          // Turnaround: first TA bit was released; drive zero now on reads
          ST_TA: begin
            if (is_rd_reg) begin
              mdio_o    <= 1'b0;
              mdio_oe_o <= 1'b1;
              sh_reg    <= half_of(snap_reg, ra_reg[0]);
              cnt_reg   <= 5'h00;
              state_reg <= ST_DATA;
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == `EMRS_OP_LAST) begin
                cnt_reg   <= 5'h00;
                state_reg <= ST_DATA;
              end
            end
          end
          // Sixteen data bits, MSB first, either direction
          ST_DATA: begin
            cnt_reg <= cnt_reg + 5'h01;
            if (is_rd_reg) begin
              if (cnt_reg == `EMRS_DATA_END) begin
                mdio_oe_o <= 1'b0;
                mdio_o    <= 1'b0;
                state_reg <= ST_IDLE;
                reg_rd_done_o <= rd_fx_reg;
                rd_fx_reg     <= 1'b0;
              end else begin
                mdio_o <= sh_reg[15];
                sh_reg <= {sh_reg[14:0], 1'b0};
              end
            end else begin
              sh_reg <= wr_data;
              if (cnt_reg == `EMRS_DATA_LAST) begin
                state_reg <= ST_IDLE;
                if (wr_open_reg && (wr_addr_reg == wr_word) &&
                    (wr_half_reg != ra_reg[0])) begin
                  reg_wr_o    <= 1'b1;
                  reg_addr_o  <= {wr_word, 2'h0};
                  reg_wdata_o <= ra_reg[0] ? {wr_data, wr_stage_reg} :
                                             {wr_stage_reg, wr_data};
                  wr_open_reg <= 1'b0;
                end else if (wr_open_reg && (wr_addr_reg == wr_word)) begin
                  wr_open_reg <= 1'b0;
                end else begin
                  wr_open_reg  <= 1'b1;
                  wr_half_reg  <= ra_reg[0];
                  wr_addr_reg  <= wr_word;
                  wr_stage_reg <= wr_data;
                end
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            mdio_oe_o <= 1'b0;
          end
        endcase
      end

      // reset end drops pair; placed last so it wins
      if (busy_d_reg && !sys_busy_i) begin
        rd_open_reg <= 1'b0;
      end
    end
  end

endmodule // emrs_top

// [hdl/emrs_defs.vh]
// Notes on behaviour
// - Answer only PHY addresses 16 to 31.
// - Protocol active only when strap equals 01b.
// - PHY bits 3:0 and register field form address.
// - Register field bit 0 selects half; pair halves.
// - Sample and launch on MDC rising edge.
// - MDIO released except while returning read data.
// - MSB first; high half bytes 3,2; low 1,0.
// - Read: Z, then zero, then 16 bits, release.
// - Never drive MDIO during a write frame.
// - Same-half read pair is invalid; restart pairing.
// - Registers marked 16-bit complete on one read.
// - Snapshot whole word at first half read.
// - Read side effects only after second half.
// - Unused addresses read back as all zeros.
// - Reset ending mid-pair drops read pairing.
// - Same-half write pair is discarded entirely.
`ifndef EMRS_DEFS_VH
`define EMRS_DEFS_VH

// Frame layout
`define EMRS_PRE_ONES    6'h20
`define EMRS_STRAP_EN    2'h1
`define EMRS_OP_RD       2'h2
`define EMRS_OP_WR       2'h1
`define EMRS_FIELD_LAST  5'h04
`define EMRS_OP_LAST     5'h01
`define EMRS_DATA_LAST   5'h0f
`define EMRS_DATA_END    5'h10
`define EMRS_PA_EXT_BIT  4

// Read pair kinds
`define EMRS_KIND_FIRST  2'h0
`define EMRS_KIND_SECOND 2'h1
`define EMRS_KIND_BAD    2'h2

// Reset values
`define EMRS_ZERO32      32'h00000000
`define EMRS_ZERO16      16'h0000

`endif

// [hdl/emrs_sync.v]
`timescale 1ns/1ps
// Two-stage synchroniser for levels entering from outside the clock domain
module emrs_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_reg;  // First stage, read only by the second
  reg [W-1:0] sync_reg;  // Second stage, safe to use

  // Both stages freeze with the clock enable
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else if (ce_i) begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule // emrs_sync

// [verification/emrs_monitor.sv]
`timescale 1ns/1ps
// Pin-level checker for the management slave
module emrs_monitor (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  input wire logic        mdc_i,
  input wire logic        mdio_i,
  input wire logic        mdio_o,
  input wire logic        mdio_oe_o,
  input wire logic [1:0]  mode_strap_i,
  input wire logic        sys_busy_i,
  input wire logic [9:0]  reg_addr_o,
  input wire logic        reg_rd_o,
  input wire logic [31:0] reg_rdata_i,
  input wire logic        reg_valid_i,
  input wire logic        reg_rd16_i,
  input wire logic        reg_rd_done_o,
  input wire logic        reg_wr_o,
  input wire logic [31:0] reg_wdata_o
);
  logic       mdc_q;      // Raw MDC one clock ago
  logic [3:0] since_rise; // Clocks since MDC rose, saturates
  logic [7:0] oe_cnt;     // Clocks the pin has been driven
  logic       blank_rd;   // Last fetch was unmapped
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Helper state; raw pin edge, so the synchroniser delay shows
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mdc_q      <= 1'b0;
      since_rise <= 4'hf;
      oe_cnt     <= 8'h00;
      blank_rd   <= 1'b0;
    end else begin
      mdc_q      <= mdc_i;
      since_rise <= (mdc_i && !mdc_q) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hf};
      oe_cnt     <= mdio_oe_o ? oe_cnt + 8'h01 : 8'h00;
      if (reg_rd_o) begin
        blank_rd <= !reg_valid_i;
      end
    end
  end
  sequence s_drive_start; ##[1:12] $rose(mdio_oe_o) ##0 !mdio_o; endsequence
  sequence s_release; !mdio_oe_o ##0 $past(mdio_oe_o, 2); endsequence
  property p_fetch_drive; reg_rd_o |-> s_drive_start; endproperty
  property p_drive_len; $fell(mdio_oe_o) |-> oe_cnt inside {[132:140]}; endproperty
  property p_launch;
    ($changed(mdio_o) && mdio_oe_o) || $changed(mdio_oe_o) |-> since_rise inside {[1:7]};
  endproperty
  property p_rd_one; reg_rd_o |=> !reg_rd_o; endproperty
  property p_wr_one; reg_wr_o |=> !reg_wr_o [*8]; endproperty
  property p_done_end; reg_rd_done_o |-> s_release; endproperty
  property p_blank_zero; blank_rd && mdio_oe_o |-> !mdio_o; endproperty
  property p_strap_off;
    mode_strap_i != 2'h1 && $past(mode_strap_i, 4) != 2'h1 |-> !$rose(mdio_oe_o) && !reg_rd_o;
  endproperty
  a_fetch_drive: assert property (p_fetch_drive) else $error("no drive after fetch");
  a_drive_len: assert property (p_drive_len) else $error("drive length wrong");
  a_launch: assert property (p_launch) else $error("launch off MDC rise");
  a_rd_one: assert property (p_rd_one) else $error("fetch too long");
  a_wr_one: assert property (p_wr_one) else $error("write strobe repeats");
  a_done_end: assert property (p_done_end) else $error("done not at release");
  a_blank_zero: assert property (p_blank_zero) else $error("unmapped not zero");
  a_strap_off: assert property (p_strap_off) else $error("active with strap off");
endmodule // emrs_monitor

bind emrs_top emrs_monitor u_emrs_monitor (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .mdc_i(mdc_i), .mdio_i(mdio_i),
  .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mode_strap_i(mode_strap_i),
  .sys_busy_i(sys_busy_i), .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o),
  .reg_rdata_i(reg_rdata_i), .reg_valid_i(reg_valid_i), .reg_rd16_i(reg_rd16_i),
  .reg_rd_done_o(reg_rd_done_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o));

// [verification/emrs_host.sv]
`timescale 1ns/1ps
// Management host; MDC stands low between frames
module emrs_host (
  input  wire logic mdio_i, // Resolved line
  output logic      mdc_o,  // Management clock
  output logic      drv_o,  // Host drives line
  output logic      dat_o   // Host drive value
);
  initial begin
    mdc_o = 1'b0;
    drv_o = 1'b0;
    dat_o = 1'b1;
  end
  // set after fall, sample at rise
  task automatic tick(input logic d, input logic en, output logic s);
    drv_o = en;
    dat_o = d;
    #400 mdc_o = 1'b1;
    s = mdio_i;
    #400 mdc_o = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [17:0] rsp);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffffffff, 2'b01, rd, !rd, pa, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      tick(bits[i], !rd || i > 17, s);
      if (i < 18) rsp[i] = s;
    end
    // Idle bit: the slave has already released the line just after the MDC rise that sampled the last data bit
    tick(1'b1, 1'b0, s);
  endtask
endmodule // emrs_host

// [verification/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench for the extended management slave
module testbench;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [1:0]  mode_strap_i = 2'h1;
  logic        sys_busy_i = 1'b0;
  logic        drove = 1'b0;         // Slave drove the line
  logic [31:0] base = 32'h13579bdf; // Register file seed
  logic [31:0] last_wdata;
  logic [9:0]  last_waddr;
  logic [17:0] rsp;                  // Turnaround and data samples
  wire         mdc_i, mdio_i, mdio_o, mdio_oe_o, host_drv, host_dat;
  wire         reg_rd_o, reg_rd_done_o, reg_wr_o;
  wire  [9:0]  reg_addr_o;
  wire  [31:0] reg_wdata_o;
  int          n_errors = 0, samples_checked = 0, n_done = 0, n_wr = 0, cycles = 0;
  // Register side; unmapped data is junk on purpose
  wire  [31:0] reg_rdata_i = base ^ {22'h0, reg_addr_o};
  wire         reg_valid_i = reg_addr_o != 10'h3fc;
  wire         reg_rd16_i = reg_addr_o == 10'h004;
  assign mdio_i = mdio_oe_o ? mdio_o : (host_drv ? host_dat : 1'b1);
  always #50 clk_i = ~clk_i;
  emrs_top u_emrs_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .mdc_i(mdc_i), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mode_strap_i(mode_strap_i),
    .sys_busy_i(sys_busy_i), .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o),
    .reg_rdata_i(reg_rdata_i), .reg_valid_i(reg_valid_i), .reg_rd16_i(reg_rd16_i),
    .reg_rd_done_o(reg_rd_done_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o));
  emrs_host u_emrs_host (.mdio_i(mdio_i), .mdc_o(mdc_i), .drv_o(host_drv), .dat_o(host_dat));
  // Strobe counters and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (reg_rd_done_o === 1'b1) n_done++;
    if (mdio_oe_o === 1'b1) drove = 1'b1;
    if (reg_wr_o === 1'b1) begin
      n_wr++;
      last_wdata = reg_wdata_o;
      last_waddr = reg_addr_o;
    end
    if (cycles == 30000) begin
      n_errors++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected word; unmapped reads back as zero
  function automatic logic [31:0] word(input logic [9:0] a);
    return (a == 10'h3fc) ? 32'h0 : base ^ {22'h0, a};
  endfunction
  // One frame, then let the answer strobes land
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd);
    u_emrs_host.frame(rd, pa, ra, wd, rsp);
    repeat (8) @(negedge clk_i);
  endtask
  // Whole pair, register bumped between halves
  task automatic pair(input logic [4:0] pa, input logic [4:0] ra, input logic hi);
    logic [31:0] w;
    logic [9:0]  a;
    int          d;
    a = {pa[3:0], ra[4:1], 2'b00};
    w = word(a);
    d = n_done;
    xfer(1'b1, pa, {ra[4:1], hi}, 16'h0);
    check({14'h0, rsp}, {16'h2, hi ? w[31:16] : w[15:0]});
    check(n_done, d);
    base = base + 32'h01010101;
    xfer(1'b1, pa, {ra[4:1], !hi}, 16'h0);
    check({14'h0, rsp}, {16'h2, hi ? w[15:0] : w[31:16]});
    check(reg_addr_o, a);
    check(n_done, d + 1);
  endtask
  task automatic t_refuse;
    xfer(1'b1, 5'h0f, 5'h03, 16'h0);
    check(rsp, 18'h3ffff);
    mode_strap_i = 2'h2;
    repeat (8) @(negedge clk_i);
    xfer(1'b1, 5'h13, 5'h0b, 16'h0);
    check(rsp, 18'h3ffff);
    mode_strap_i = 2'h1;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic t_same_half;
    logic [31:0] w;
    int          d;
    d = n_done;
    xfer(1'b1, 5'h11, 5'h07, 16'h0);
    base = base ^ 32'hffff0000;
    w = word(10'h04c);
    xfer(1'b1, 5'h11, 5'h07, 16'h0);
    check({14'h0, rsp}, {16'h2, w[31:16]});
    check(n_done, d);
    pair(5'h11, 5'h06, 1'b0);
  endtask
  task automatic t_half_reg;
    logic [31:0] w;
    int          d;
    d = n_done;
    w = word(10'h004);
    xfer(1'b1, 5'h10, 5'h03, 16'h0);
    check({14'h0, rsp}, {16'h2, w[31:16]});
    check(n_done, d + 1);
  endtask
  task automatic t_reset_mid;
    int d;
    d = n_done;
    xfer(1'b1, 5'h12, 5'h09, 16'h0);
    sys_busy_i = 1'b1;
    repeat (4) @(negedge clk_i);
    sys_busy_i = 1'b0;
    xfer(1'b1, 5'h12, 5'h08, 16'h0);
    check(n_done, d);
    xfer(1'b1, 5'h12, 5'h09, 16'h0);
    check(n_done, d + 1);
  endtask
  // mapped addresses, halves back to back
  task automatic t_write;
    int k;
    k = n_wr;
    xfer(1'b0, 5'h15, 5'h0d, 16'hbeef);
    xfer(1'b0, 5'h15, 5'h0d, 16'h1234);
    check(n_wr, k);
    xfer(1'b1, 5'h15, 5'h0d, 16'h0);
    drove = 1'b0;
    xfer(1'b0, 5'h15, 5'h0c, 16'h5a5a);
    check(n_wr, k);
    xfer(1'b0, 5'h15, 5'h0d, 16'hc3c3);
    check(n_wr, k + 1);
    check(last_wdata, 32'hc3c35a5a);
    check(last_waddr, 10'h158);
    check(drove, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    t_refuse;
    pair(5'h13, 5'h0a, 1'b1);
    pair(5'h1a, 5'h14, 1'b0);
    pair(5'h1f, 5'h1e, 1'b1);
    t_same_half;
    t_half_reg;
    t_reset_mid;
    t_write;
    end_of_test;
  end
endmodule // testbench
